// [verilog/aias_sequencer.sv]
// analog input acquisition sequencer: registers, clock and trigger routing, burst control
// assumes dividers, converter and capture buffer outside; pins arrive on the link clock
`timescale 1ns/10ps
`default_nettype none
`include "aias_regs.svh"

module aias_sequencer #(
   parameter int NCH = 8
) (
   input  wire logic                   i_clock,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_link_clock,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   input  wire logic [6:0]             i_addr,
   input  wire logic [31:0]            i_wdata,
   output logic      [31:0]            o_rdata,
   input  wire logic                   i_sample_div_tick,
   input  wire logic                   i_out_sample_div_tick,
   input  wire logic                   i_trig_div_tick,
   input  wire logic                   i_out_trig_div_tick,
   input  wire logic                   i_ext_sample_clock_in,
   input  wire logic                   i_ext_trigger_in,
   output logic                        o_sample_divider_enable,
   output logic                        o_trigger_divider_enable,
   output logic                        o_sample_clock_echo,
   output logic                        o_trigger_echo,
   output logic                        o_conv_start,
   input  wire logic                   i_conv_done,
   input  wire logic [NCH*18-1:0]      i_conv_data,
   output logic                        o_wr_valid,
   output logic      [31:0]            o_wr_word,
   output logic      [2:0]             o_voltage_span,
   output logic      [4:0]             o_input_mux,
   output logic                        o_ext_inputs_off,
   output logic      [1:0]             o_filter_group_a,
   output logic      [1:0]             o_filter_group_b,
   output logic                        o_clock_follower,
   output logic                        o_trigger_follower
);

   // highest active channel carries the marker on the last sample of a burst
   function automatic logic [2:0] last_active(input logic [7:0] m);
      logic [2:0] r;
      r = 3'h0;
      for (int k = 0; k < NCH; k++) begin
         if (m[k]) begin
            r = 3'(k);
         end
      end
      return r;
   endfunction

   // link domain: pins and reset synchronised on the link clock
   // link logic resets from its own synchronised copy of i_rst_n, so hold reset for three link edges
   // a pin pulse shorter than one link period can be missed; the far side must hold it longer
   logic       lrst_m_q, lrst_q;
   logic       ck_m_q, ck_s_q, ck_p_q, ck_tog_q;
   logic       tg_m_q, tg_s_q, tg_p_q, tg_tog_q;
   logic       ck_p_d, ck_tog_d, tg_p_d, tg_tog_d;

   always_comb begin
      ck_p_d   = ck_s_q;
      tg_p_d   = tg_s_q;
      ck_tog_d = ck_tog_q ^ (ck_s_q & ~ck_p_q);
      tg_tog_d = tg_tog_q ^ (tg_s_q & ~tg_p_q);
      if (!lrst_q) begin
         ck_p_d   = 1'b0;
         tg_p_d   = 1'b0;
         ck_tog_d = 1'b0;
         tg_tog_d = 1'b0;
      end
   end

   always_ff @(posedge i_link_clock) begin
      lrst_m_q <= i_rst_n;
      lrst_q   <= lrst_m_q;
      ck_m_q   <= i_ext_sample_clock_in;
      ck_s_q   <= ck_m_q;
      tg_m_q   <= i_ext_trigger_in;
      tg_s_q   <= tg_m_q;
      ck_p_q   <= ck_p_d;
      tg_p_q   <= tg_p_d;
      ck_tog_q <= ck_tog_d;
      tg_tog_q <= tg_tog_d;
   end

   // system domain state
   logic              ckx_m_q, ckx_s_q, ckx_p_q, tgx_m_q, tgx_s_q, tgx_p_q;
   logic              smp_stb_q, smp_stb_d, trg_stb_q, trg_stb_d;
   logic              burst_en_q, burst_en_d, busy_q, busy_d;
   logic              store_en_q, store_en_d, sdiv_q, sdiv_d, tdiv_q, tdiv_d;
   logic [7:0]        mask_q, mask_d;
   logic [2:0]        span_q, span_d;
   logic              sync_oe_q, sync_oe_d;
   logic [1:0]        csel_q, csel_d, tsel_q, tsel_d, fa_q, fa_d, fb_q, fb_d;
   logic [4:0]        mode_q, mode_d;
   logic              test_q, test_d;
   logic [23:0]       size_q, size_d, done_q, done_d;
   aias_pkg::aias_state_t state_q, state_d;
   logic [2:0]        ch_q, ch_d, lastch_q, lastch_d;
   logic              last_q, last_d;
   logic [NCH*18-1:0] data_q, data_d;
   logic [31:0]       rdata_q, rdata_d, wword_q, wword_d;
   logic              wvalid_q, wvalid_d, conv_q, conv_d, echo_s_q, echo_s_d, echo_t_q, echo_t_d;
   logic              ext_ck_evt, ext_tg_evt, samp_evt, trig_evt, take;
   logic              wr_bcr, wr_setup, wr_count;
   logic              cfol_q, cfol_d, tfol_q, tfol_d;

   // toggles change at most every other link edge, slow enough for the three-stage crossing
   assign ext_ck_evt = ckx_s_q ^ ckx_p_q;
   assign ext_tg_evt = tgx_s_q ^ tgx_p_q;
   assign wr_bcr     = i_wr && (i_addr == `AIAS_OFS_BCR);
   assign wr_setup   = i_wr && (i_addr == `AIAS_OFS_SETUP);
   assign wr_count   = i_wr && (i_addr == `AIAS_OFS_COUNT);

   always_comb begin
      // selected source, reserved code yields nothing; host strobe overrides
      case (csel_q)
         `AIAS_SRC_DIV:  samp_evt = i_sample_div_tick & sdiv_q;
         `AIAS_SRC_ODIV: samp_evt = i_out_sample_div_tick;
         `AIAS_SRC_EXT:  samp_evt = ext_ck_evt;
         default:        samp_evt = 1'b0;
      endcase
      samp_evt = samp_evt | smp_stb_q;
      case (tsel_q)
         `AIAS_SRC_DIV:  trig_evt = i_trig_div_tick & tdiv_q;
         `AIAS_SRC_ODIV: trig_evt = i_out_trig_div_tick;
         `AIAS_SRC_EXT:  trig_evt = ext_tg_evt;
         default:        trig_evt = 1'b0;
      endcase
      trig_evt = trig_evt | trg_stb_q;
      // in burst mode only a running burst accepts sample clocks
      // events landing mid-conversion are dropped, not queued; there is no buffering
      take = samp_evt && (state_q == aias_pkg::AIAS_IDLE) && (!burst_en_q || busy_q);
   end

   always_comb begin
      smp_stb_d  = wr_bcr & i_wdata[`AIAS_BCR_SMP_STB];
      trg_stb_d  = wr_bcr & i_wdata[`AIAS_BCR_TRG_STB];
      burst_en_d = wr_bcr ? i_wdata[`AIAS_BCR_BURST_EN] : burst_en_q;
      store_en_d = wr_bcr ? i_wdata[`AIAS_BCR_STORE_EN] : store_en_q;
      sdiv_d     = wr_bcr ? i_wdata[`AIAS_BCR_SDIV_EN] : sdiv_q;
      tdiv_d     = wr_bcr ? i_wdata[`AIAS_BCR_TDIV_EN] : tdiv_q;
      mask_d     = mask_q;
      span_d     = span_q;
      sync_oe_d  = sync_oe_q;
      csel_d     = csel_q;
      tsel_d     = tsel_q;
      mode_d     = mode_q;
      fa_d       = fa_q;
      fb_d       = fb_q;
      size_d     = wr_count ? i_wdata[`AIAS_COUNT_MSB:0] : size_q;
      if (wr_setup) begin
         mask_d    = i_wdata[`AIAS_MASK_MSB:`AIAS_MASK_LSB];
         sync_oe_d = i_wdata[`AIAS_SYNC_OE];
         // reserved codes leave the current routing in place
         if (i_wdata[`AIAS_SPAN_MSB:`AIAS_SPAN_LSB] <= `AIAS_SPAN_MAX) begin
            span_d = i_wdata[`AIAS_SPAN_MSB:`AIAS_SPAN_LSB];
         end
         if (i_wdata[`AIAS_CSEL_MSB:`AIAS_CSEL_LSB] <= `AIAS_SRC_EXT) begin
            csel_d = i_wdata[`AIAS_CSEL_MSB:`AIAS_CSEL_LSB];
         end
         if (i_wdata[`AIAS_TSEL_MSB:`AIAS_TSEL_LSB] <= `AIAS_SRC_EXT) begin
            tsel_d = i_wdata[`AIAS_TSEL_MSB:`AIAS_TSEL_LSB];
         end
         if (i_wdata[`AIAS_MODE_MSB:`AIAS_MODE_LSB] <= `AIAS_MODE_REF ||
             i_wdata[`AIAS_MODE_MSB:`AIAS_MODE_LSB] >= `AIAS_MODE_OUTPIN) begin
            mode_d = i_wdata[`AIAS_MODE_MSB:`AIAS_MODE_LSB];
         end
         if (i_wdata[`AIAS_FA_MSB:`AIAS_FA_LSB] != `AIAS_FILT_RSVD) begin
            fa_d = i_wdata[`AIAS_FA_MSB:`AIAS_FA_LSB];
         end
         if (i_wdata[`AIAS_FB_MSB:`AIAS_FB_LSB] != `AIAS_FILT_RSVD) begin
            fb_d = i_wdata[`AIAS_FB_MSB:`AIAS_FB_LSB];
         end
      end
      test_d = mode_d > `AIAS_MODE_SE;
      // follower flags are registered so the outputs come straight from flip-flops
      cfol_d = (csel_d == `AIAS_SRC_EXT);
      tfol_d = (tsel_d == `AIAS_SRC_EXT);

      // register read: one cycle latency, unmapped offsets read zero
      rdata_d = 32'h0000_0000;
      if (i_rd) begin
         case (i_addr)
            `AIAS_OFS_BCR: begin
               rdata_d[`AIAS_BCR_BURST_EN] = burst_en_q;
               rdata_d[`AIAS_BCR_BUSY]     = busy_q;
               rdata_d[`AIAS_BCR_STORE_EN] = store_en_q;
               rdata_d[`AIAS_BCR_SDIV_EN]  = sdiv_q;
               rdata_d[`AIAS_BCR_TDIV_EN]  = tdiv_q;
            end
            `AIAS_OFS_SETUP: begin
               rdata_d[`AIAS_MASK_MSB:`AIAS_MASK_LSB] = mask_q;
               rdata_d[`AIAS_SPAN_MSB:`AIAS_SPAN_LSB] = span_q;
               rdata_d[`AIAS_SYNC_OE]                 = sync_oe_q;
               rdata_d[`AIAS_CSEL_MSB:`AIAS_CSEL_LSB] = csel_q;
               rdata_d[`AIAS_TSEL_MSB:`AIAS_TSEL_LSB] = tsel_q;
               rdata_d[`AIAS_MODE_MSB:`AIAS_MODE_LSB] = mode_q;
               rdata_d[`AIAS_FA_MSB:`AIAS_FA_LSB]     = fa_q;
               rdata_d[`AIAS_FB_MSB:`AIAS_FB_LSB]     = fb_q;
            end
            `AIAS_OFS_COUNT: rdata_d[`AIAS_COUNT_MSB:0] = size_q;
            default:         rdata_d = 32'h0000_0000;
         endcase
      end

      // echo pulses follow the internal events only when enabled
      echo_s_d = sync_oe_q & samp_evt;
      echo_t_d = sync_oe_q & trig_evt;

      // burst arming: a trigger only counts while armed and idle
      busy_d = busy_q;
      done_d = done_q;
      if (burst_en_q && !busy_q && trig_evt) begin
         busy_d = 1'b1;
         done_d = 24'h000000;
      end

      state_d  = state_q;
      ch_d     = ch_q;
      last_d   = last_q;
      lastch_d = lastch_q;
      data_d   = data_q;
      conv_d   = 1'b0;
      wvalid_d = 1'b0;
      wword_d  = wword_q;
      case (state_q)
         aias_pkg::AIAS_IDLE: begin
            if (take) begin
               conv_d   = 1'b1;
               state_d  = aias_pkg::AIAS_CONV;
               done_d   = done_q + 24'h000001;
               lastch_d = last_active(mask_q);
               // zero size never reaches its count, so the burst runs on
               last_d   = busy_q && (size_q != 24'h000000) &&
                          (done_q + 24'h000001 == size_q);
            end
         end
         aias_pkg::AIAS_CONV: begin
            if (i_conv_done) begin
               data_d  = i_conv_data;
               ch_d    = 3'h0;
               state_d = aias_pkg::AIAS_EMIT;
            end
         end
         aias_pkg::AIAS_EMIT: begin
            // one channel slot per cycle, inactive ones write nothing; the pass always takes eight cycles
            // no back-pressure: the capture buffer must accept one word per cycle
            if (mask_q[ch_q] && store_en_q) begin
               wvalid_d = 1'b1;
               wword_d  = 32'h0000_0000;
               wword_d[`AIAS_DATA_W-1:0]             = data_q[ch_q*`AIAS_DATA_W +: `AIAS_DATA_W];
               wword_d[`AIAS_W_CH_MSB:`AIAS_W_CH_LSB] = ch_q;
               wword_d[`AIAS_W_MARK]                  = last_q && (ch_q == lastch_q);
            end
            ch_d = ch_q + 3'h1;
            if (ch_q == `AIAS_LAST_CH) begin
               state_d = aias_pkg::AIAS_IDLE;
               if (last_q) begin
                  busy_d = 1'b0;
               end
               last_d = 1'b0;
            end
         end
         default: state_d = aias_pkg::AIAS_IDLE;
      endcase
      // clearing burst mode, or writing a count above the samples already taken, ends a zero-size burst
      if (!burst_en_q) begin
         busy_d = 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         ckx_m_q    <= 1'b0;
         ckx_s_q    <= 1'b0;
         ckx_p_q    <= 1'b0;
         tgx_m_q    <= 1'b0;
         tgx_s_q    <= 1'b0;
         tgx_p_q    <= 1'b0;
         smp_stb_q  <= 1'b0;
         trg_stb_q  <= 1'b0;
         burst_en_q <= 1'b0;
         busy_q     <= 1'b0;
         store_en_q <= 1'b0;
         sdiv_q     <= 1'b0;
         tdiv_q     <= 1'b0;
         mask_q     <= `AIAS_MASK_RST;
         span_q     <= `AIAS_SPAN_RST;
         sync_oe_q  <= 1'b0;
         csel_q     <= `AIAS_SRC_DIV;
         tsel_q     <= `AIAS_SRC_DIV;
         mode_q     <= 5'h00;
         fa_q       <= 2'h0;
         fb_q       <= 2'h0;
         test_q     <= 1'b0;
         cfol_q     <= 1'b0;
         tfol_q     <= 1'b0;
         size_q     <= `AIAS_COUNT_RST;
         done_q     <= 24'h000000;
         state_q    <= aias_pkg::AIAS_IDLE;
         ch_q       <= 3'h0;
         lastch_q   <= 3'h0;
         last_q     <= 1'b0;
         data_q     <= '0;
         rdata_q    <= 32'h0000_0000;
         wword_q    <= 32'h0000_0000;
         wvalid_q   <= 1'b0;
         conv_q     <= 1'b0;
         echo_s_q   <= 1'b0;
         echo_t_q   <= 1'b0;
      end else begin
         // toggles cross as levels; the event is the change after the second stage
         ckx_m_q    <= ck_tog_q;
         ckx_s_q    <= ckx_m_q;
         ckx_p_q    <= ckx_s_q;
         tgx_m_q    <= tg_tog_q;
         tgx_s_q    <= tgx_m_q;
         tgx_p_q    <= tgx_s_q;
         smp_stb_q  <= smp_stb_d;
         trg_stb_q  <= trg_stb_d;
         burst_en_q <= burst_en_d;
         busy_q     <= busy_d;
         store_en_q <= store_en_d;
         sdiv_q     <= sdiv_d;
         tdiv_q     <= tdiv_d;
         mask_q     <= mask_d;
         span_q     <= span_d;
         sync_oe_q  <= sync_oe_d;
         csel_q     <= csel_d;
         tsel_q     <= tsel_d;
         mode_q     <= mode_d;
         fa_q       <= fa_d;
         fb_q       <= fb_d;
         test_q     <= test_d;
         cfol_q     <= cfol_d;
         tfol_q     <= tfol_d;
         size_q     <= size_d;
         done_q     <= done_d;
         state_q    <= state_d;
         ch_q       <= ch_d;
         lastch_q   <= lastch_d;
         last_q     <= last_d;
         data_q     <= data_d;
         rdata_q    <= rdata_d;
         wword_q    <= wword_d;
         wvalid_q   <= wvalid_d;
         conv_q     <= conv_d;
         echo_s_q   <= echo_s_d;
         echo_t_q   <= echo_t_d;
      end
   end

   assign o_rdata                  = rdata_q;
   assign o_sample_divider_enable  = sdiv_q;
   assign o_trigger_divider_enable = tdiv_q;
   assign o_sample_clock_echo      = echo_s_q;
   assign o_trigger_echo           = echo_t_q;
   assign o_conv_start             = conv_q;
   assign o_wr_valid               = wvalid_q;
   assign o_wr_word                = wword_q;
   assign o_voltage_span           = span_q;
   assign o_input_mux              = mode_q;
   assign o_ext_inputs_off         = test_q;
   assign o_filter_group_a         = fa_q;
   assign o_filter_group_b         = fb_q;
   assign o_clock_follower         = cfol_q;
   assign o_trigger_follower       = tfol_q;

endmodule
`default_nettype wire

// [verilog/aias_regs.svh]
// register offsets, field positions and reset values of the acquisition sequencer
// assumes a 32-bit local register port with byte offsets on 7 address bits
`ifndef AIAS_REGS_SVH
`define AIAS_REGS_SVH

`define AIAS_OFS_BCR        7'h00
`define AIAS_OFS_SETUP      7'h14
`define AIAS_OFS_COUNT      7'h24

`define AIAS_BCR_SMP_STB    8
`define AIAS_BCR_BURST_EN   9
`define AIAS_BCR_BUSY       10
`define AIAS_BCR_TRG_STB    11
`define AIAS_BCR_STORE_EN   12
`define AIAS_BCR_SDIV_EN    26
`define AIAS_BCR_TDIV_EN    27

`define AIAS_MASK_LSB       0
`define AIAS_MASK_MSB       7
`define AIAS_SPAN_LSB       8
`define AIAS_SPAN_MSB       10
`define AIAS_SYNC_OE        11
`define AIAS_CSEL_LSB       12
`define AIAS_CSEL_MSB       13
`define AIAS_TSEL_LSB       14
`define AIAS_TSEL_MSB       15
`define AIAS_MODE_LSB       16
`define AIAS_MODE_MSB       20
`define AIAS_FA_LSB         24
`define AIAS_FA_MSB         25
`define AIAS_FB_LSB         26
`define AIAS_FB_MSB         27

`define AIAS_MASK_RST       8'hff
`define AIAS_SPAN_RST       3'h2
`define AIAS_SPAN_MAX       3'h4
`define AIAS_COUNT_RST      24'h000400
`define AIAS_COUNT_MSB      23
`define AIAS_SRC_DIV        2'h0
`define AIAS_SRC_ODIV       2'h1
`define AIAS_SRC_EXT        2'h2
`define AIAS_MODE_SE        5'h01
`define AIAS_MODE_REF       5'h03
`define AIAS_MODE_OUTPIN    5'h10
`define AIAS_FILT_RSVD      2'h3

`define AIAS_W_MARK         18
`define AIAS_W_CH_LSB       20
`define AIAS_W_CH_MSB       22
`define AIAS_DATA_W         18
`define AIAS_LAST_CH        3'h7

`endif

// [verilog/aias_pkg.sv]
// types shared by the acquisition sequencer
// assumes nothing beyond a SystemVerilog compiler
package aias_pkg;
   typedef enum logic [2:0] {
      AIAS_IDLE = 3'b001,
      AIAS_CONV = 3'b010,
      AIAS_EMIT = 3'b100
   } aias_state_t;
endpackage

// [tb/aias_conv_model.sv]
// converter stand-in: one result per channel a few cycles after each start
// assumes the sequencer's start pulse on the system clock
`timescale 1ns/10ps
`default_nettype none
module aias_conv_model (
   input  wire logic           i_clock,
   input  wire logic           i_start,
   output logic                o_done,
   output logic      [143:0]   o_data
);
   logic [3:0] dly_q = 4'h0;
   always @(posedge i_clock) dly_q <= {dly_q[2:0], i_start};
   assign o_done = dly_q[3];
   // channel number in the top data bits lets the bench see pairing; data is garbage outside done
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         o_data[18*k +: 18] = o_done ? {3'(k), 15'h1234} : ~{3'(k), 15'h1234};
      end
   end
endmodule
`default_nettype wire

// [tb/aias_sequencer_sva.sv]
// port assertions for the acquisition sequencer
// assumes binding onto every sequencer instance, one system clock domain
`timescale 1ns/10ps
`default_nettype none
module aias_sequencer_sva (
   input  wire logic          i_clock,
   input  wire logic          i_rst_n,
   input  wire logic          i_rd,
   input  wire logic [31:0]   o_rdata,
   input  wire logic          o_conv_start,
   input  wire logic          i_conv_done,
   input  wire logic          o_wr_valid,
   input  wire logic [31:0]   o_wr_word,
   input  wire logic [2:0]    o_voltage_span,
   input  wire logic [4:0]    o_input_mux,
   input  wire logic          o_ext_inputs_off
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   AST_SPAN_LEGAL: assert property (o_voltage_span <= 3'h4) else $error("span code out of range");
   AST_MODE_LEGAL: assert property (!(o_input_mux inside {[5'h04:5'h0f]})) else $error("mode reserved");
   AST_TEST_OFF: assert property (o_ext_inputs_off == (o_input_mux > 5'h01)) else $error("inputs off wrong");
   AST_CONV_PULSE: assert property (o_conv_start |=> !o_conv_start) else $error("start too long");
   AST_FIRST_SLOT: assert property (o_wr_valid && o_wr_word[22:20] == 3'h0 |-> $past(i_conv_done, 2))
      else $error("channel 0 slot late");
   AST_CH_ASCEND: assert property (o_wr_valid && $past(o_wr_valid)
      |-> o_wr_word[22:20] == $past(o_wr_word[22:20]) + 3'h1) else $error("channel order");
   AST_WORD_SPARE: assert property (o_wr_valid |-> o_wr_word[31:23] == 9'h0 && !o_wr_word[19])
      else $error("spare word bits set");
   AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("read data not idle");
endmodule
bind aias_sequencer aias_sequencer_sva u_sva (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_rd(i_rd),
   .o_rdata(o_rdata), .o_conv_start(o_conv_start), .i_conv_done(i_conv_done), .o_wr_valid(o_wr_valid),
   .o_wr_word(o_wr_word), .o_voltage_span(o_voltage_span), .o_input_mux(o_input_mux),
   .o_ext_inputs_off(o_ext_inputs_off));
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the acquisition sequencer
// assumes the converter model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic         clk = 1'b0;
   logic         lclk = 1'b0;
   logic         rst_n = 1'b0;
   logic         wr = 1'b0;
   logic         rd = 1'b0;
   logic [6:0]   addr = 7'h00;
   logic [31:0]  wdata = 32'h0;
   logic [5:0]   tk = 6'h00;
   logic [31:0]  rdata, ww;
   logic [143:0] cdata;
   logic         cstart, cdone, wv, exoff, cfol, tfol, sden, tden, secho, techo;
   logic [2:0]   span;
   logic [4:0]   mux;
   logic [1:0]   fga, fgb;
   logic [31:0]  q[$];
   logic [4:0]   md[8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h17, 5'h18, 5'h1f};
   int           fail_count = 0, num_checks = 0, nconv = 0, necho = 0, cyc = 0, n0, e0, ntrig = 0, t0;
   initial forever #5 clk = ~clk;
   initial begin
      #3;
      forever #16 lclk = ~lclk;
   end
   aias_conv_model u_conv (.i_clock(clk), .i_start(cstart), .o_done(cdone), .o_data(cdata));
   aias_sequencer dut (.i_clock(clk), .i_rst_n(rst_n), .i_link_clock(lclk), .i_wr(wr), .i_rd(rd),
      .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_sample_div_tick(tk[0]), .i_out_sample_div_tick(tk[1]),
      .i_trig_div_tick(tk[3]), .i_out_trig_div_tick(tk[4]), .i_ext_sample_clock_in(tk[2]), .i_ext_trigger_in(tk[5]),
      .o_sample_divider_enable(sden), .o_trigger_divider_enable(tden), .o_sample_clock_echo(secho),
      .o_trigger_echo(techo), .o_conv_start(cstart), .i_conv_done(cdone), .i_conv_data(cdata), .o_wr_valid(wv),
      .o_wr_word(ww), .o_voltage_span(span), .o_input_mux(mux), .o_ext_inputs_off(exoff),
      .o_filter_group_a(fga), .o_filter_group_b(fgb), .o_clock_follower(cfol), .o_trigger_follower(tfol));
   // the converter answers on its own schedule, so words are collected and judged afterwards
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wv === 1'b1) q.push_back(ww);
      if (cstart === 1'b1) nconv <= nconv + 1;
      if (secho === 1'b1) necho <= necho + 1;
      if (techo === 1'b1) ntrig <= ntrig + 1;
      if (cyc == 20000) begin
         $display("CHECK FAILED at %0t: timeout", $time);
         fail_count++;
         results();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [6:0] a, input logic [31:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk) #1;
      wr = 1'b0;
      // an idle edge keeps a following call from raising the strobe in the same step
      @(posedge clk) #1;
   endtask
   task automatic rreg(input logic [6:0] a, input logic [31:0] exp);
      addr = a;
      rd = 1'b1;
      @(posedge clk) #1;
      rd = 1'b0;
      chk(rdata, exp);
      @(posedge clk) #1;
   endtask
   task automatic pulse(input int k);
      if (k == 2 || k == 5) begin
         @(posedge lclk) #1;
         tk[k] = 1'b1;
         repeat (3) @(posedge lclk);
         #1 tk[k] = 1'b0;
         @(posedge clk) #1;
      end else begin
         tk[k] = 1'b1;
         @(posedge clk) #1;
         tk[k] = 1'b0;
      end
      repeat (30) @(posedge clk);
      #1;
   endtask
   task automatic words(input logic [7:0] m, input int n, input logic mk);
      for (int s = 1; s <= n; s++)
         for (int c = 0; c < 8; c++)
            if (m[c]) chk(q.pop_front(), {9'h0, 3'(c), 1'b0, mk && s == n && (m >> (c + 1)) == 0, 3'(c), 15'h1234});
      chk(q.size(), 0);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      rreg(7'h14, 32'h000002ff);
      rreg(7'h24, 32'h00000400);
      rreg(7'h00, 32'h0);
      rreg(7'h30, 32'h0);
      chk({cfol, tfol, sden, tden, secho, techo}, 32'h0);
      wreg(7'h14, 32'h0304f50f);
      rreg(7'h14, 32'h0000020f);
      for (int i = 0; i < 8; i++) begin
         wreg(7'h14, {4'h0, 2'((i + 1) % 3), 2'(i % 3), 3'h0, md[i], 4'h0, 1'b0, 3'(i % 5), 8'hff});
         @(posedge clk) #1;
         chk({span, mux, exoff, fga, fgb}, {3'(i % 5), md[i], md[i] > 5'h01, 2'(i % 3), 2'((i + 1) % 3)});
      end
      $display("test registers done");
      wreg(7'h14, 32'h00000aa5);
      q.delete();
      n0 = nconv;
      e0 = necho;
      wreg(7'h00, 32'h00001100);
      repeat (30) @(posedge clk);
      #1 words(8'ha5, 1, 1'b0);
      chk(nconv - n0, 1);
      chk(necho - e0, 1);
      rreg(7'h00, 32'h00001000);
      $display("test host strobe done");
      wreg(7'h14, 32'h000002ff);
      wreg(7'h00, 32'h04001000);
      q.delete();
      n0 = nconv;
      e0 = necho;
      chk(sden, 1);
      repeat (3) pulse(0);
      words(8'hff, 3, 1'b0);
      chk(necho - e0, 0);
      wreg(7'h14, 32'h000012ff);
      q.delete();
      n0 = nconv;
      pulse(0);
      pulse(1);
      chk(nconv - n0, 1);
      wreg(7'h14, 32'h00002aff);
      pulse(1);
      chk(cfol, 1);
      e0 = necho;
      pulse(2);
      chk(nconv - n0, 2);
      chk(necho - e0, 1);
      words(8'hff, 2, 1'b0);
      $display("test sample sources done");
      wreg(7'h14, 32'h00000203);
      wreg(7'h24, 32'h00000002);
      q.delete();
      wreg(7'h00, 32'h04001a00);
      rreg(7'h00, 32'h04001600);
      pulse(0);
      wreg(7'h00, 32'h04001a00);
      pulse(0);
      pulse(0);
      words(8'h03, 2, 1'b1);
      rreg(7'h00, 32'h04001200);
      $display("test burst done");
      wreg(7'h14, 32'h00004a03);
      t0 = ntrig;
      pulse(3);
      pulse(4);
      rreg(7'h00, 32'h04001600);
      pulse(0);
      pulse(0);
      words(8'h03, 2, 1'b1);
      wreg(7'h14, 32'h00008a03);
      wreg(7'h24, 32'h00000000);
      chk(tfol, 1);
      pulse(5);
      repeat (3) pulse(0);
      words(8'h03, 3, 1'b0);
      rreg(7'h00, 32'h04001600);
      chk(ntrig - t0, 2);
      wreg(7'h00, 32'h0c001000);
      rreg(7'h00, 32'h0c001000);
      chk(tden, 1);
      $display("test trigger sources done");
      results();
   end
endmodule
`default_nettype wire
